// ---- hw/tcr_timer.sv ----
// timer 2 control register with counter, reload pair and clock selection
`timescale 1ns/1ns
module tcr_timer
    import tcr_pkg::*;
#(
    parameter int SYS_DIV = SYS_DIVIDE,
    parameter int LF_DIV = LF_DIVIDE
)
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic SFR_BIT_WR_I,
    input wire logic [2:0] SFR_BIT_SEL_I,
    input wire logic SFR_BIT_VAL_I,
    input wire logic SFR_RD_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic UPPER_BYTE_CLOCK_SELECT_I,
    input wire logic LOWER_BYTE_CLOCK_SELECT_I,
    input wire logic TIMER_IRQ_ENABLE_I,
    input wire logic COMPARATOR0_I,
    input wire logic LF_OSC_I,
    output logic TIMER_IRQ_O
);
    generate
        if (SYS_DIV < 2 || SYS_DIV > 15 || LF_DIV < 2 || LF_DIV > 8)
        begin : g_bad_div
            $error("tcr_timer: divider parameter out of range");
        end
    endgenerate

    localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] LF_LAST = 3'(LF_DIV - 1);

    logic [7:0] ctl_r;
    logic [7:0] ctl_wr;
    logic [7:0] cnt_l_r;
    logic [7:0] cnt_h_r;
    logic [7:0] rl_l_r;
    logic [7:0] rl_h_r;
    logic [3:0] div_r;
    logic [2:0] lf_cnt_r;
    logic div_tick;
    logic lf8_tick;
    logic cmp_rise;
    logic lf_rise;
    logic alt_tick;
    logic cap_evt;
    logic tick_l;
    logic tick_h;
    logic inc_l;
    logic inc_h;
    logic ovf_l;
    logic ovf_h;
    logic ctl_sel;
    logic split;
    logic run;

    assign ctl_sel = (SFR_ADDR_I == ADDR_CONTROL);
    assign split = ctl_r[BIT_SPLIT];
    assign run = ctl_r[BIT_RUN];

    // ****************************************
    // clock sources
    // ****************************************
    tcr_sync u_sync_cmp
    (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .async_i(COMPARATOR0_I),
        .level_o(),
        .rise_o(cmp_rise)
    );

    tcr_sync u_sync_lf
    (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .async_i(LF_OSC_I),
        .level_o(),
        .rise_o(lf_rise)
    );

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            div_r <= 4'h0;
        end
        else
        begin
            div_r <= div_tick ? 4'h0 : div_r + 4'h1;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            lf_cnt_r <= 3'h0;
        end
        else if (lf_rise)
        begin
            lf_cnt_r <= lf8_tick ? 3'h0 : lf_cnt_r + 3'h1;
        end
    end

    assign div_tick = (div_r == SYS_LAST);
    assign lf8_tick = lf_rise && (lf_cnt_r == LF_LAST);

    always_comb
    begin
        case (ctl_r[BIT_SEL_HI:BIT_SEL_LO])
            SEL_DIV12_A: alt_tick = div_tick;
            SEL_COMPARATOR: alt_tick = cmp_rise;
            SEL_DIV12_B: alt_tick = div_tick;
            SEL_LF_DIV8: alt_tick = lf8_tick;
            default: alt_tick = div_tick;
        endcase
    end

    // trigger source shares the selector, upper bit picks comparator
    assign cap_evt = ctl_r[BIT_CAPTURE_EN] &&
        (ctl_r[BIT_SEL_HI] ? cmp_rise : lf8_tick);
    // in 16-bit mode the whole counter follows the lower byte select
    assign tick_l = LOWER_BYTE_CLOCK_SELECT_I || alt_tick;
    assign tick_h = UPPER_BYTE_CLOCK_SELECT_I || alt_tick;

    // ****************************************
    // counting
    // ****************************************
    assign inc_l = split ? tick_l : (run && tick_l);
    assign inc_h = split ? (run && tick_h) : (inc_l && cnt_l_r == BYTE_MAX);
    assign ovf_l = inc_l && (cnt_l_r == BYTE_MAX);
    assign ovf_h = inc_h && (cnt_h_r == BYTE_MAX);

    // a software write to a counter byte wins over the step
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            cnt_l_r <= 8'h00;
        end
        else if (SFR_WR_I && SFR_ADDR_I == ADDR_COUNT_LOW)
        begin
            cnt_l_r <= SFR_WDATA_I;
        end
        else if (ovf_l)
        begin
            cnt_l_r <= (split || ovf_h) ? rl_l_r : 8'h00;
        end
        else if (inc_l)
        begin
            cnt_l_r <= cnt_l_r + 8'h01;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            cnt_h_r <= 8'h00;
        end
        else if (SFR_WR_I && SFR_ADDR_I == ADDR_COUNT_HIGH)
        begin
            cnt_h_r <= SFR_WDATA_I;
        end
        else if (ovf_h)
        begin
            cnt_h_r <= rl_h_r;
        end
        else if (inc_h)
        begin
            cnt_h_r <= cnt_h_r + 8'h01;
        end
    end

    // capture beats a simultaneous software write to the reload pair
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            rl_l_r <= 8'h00;
            rl_h_r <= 8'h00;
        end
        else if (cap_evt)
        begin
            rl_l_r <= cnt_l_r;
            rl_h_r <= cnt_h_r;
        end
        else if (SFR_WR_I)
        begin
            if (SFR_ADDR_I == ADDR_RELOAD_LOW)
            begin
                rl_l_r <= SFR_WDATA_I;
            end
            if (SFR_ADDR_I == ADDR_RELOAD_HIGH)
            begin
                rl_h_r <= SFR_WDATA_I;
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always_comb
    begin
        ctl_wr = ctl_r;
        if (ctl_sel && SFR_WR_I)
        begin
            ctl_wr = SFR_WDATA_I;
        end
        else if (ctl_sel && SFR_BIT_WR_I)
        begin
            ctl_wr[SFR_BIT_SEL_I] = SFR_BIT_VAL_I;
        end
    end

    // hardware only sets the flags, and a set beats a clearing write
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            ctl_r <= CONTROL_RESET;
        end
        else
        begin
            ctl_r <= ctl_wr;
            ctl_r[BIT_HIGH_FLAG] <= ctl_wr[BIT_HIGH_FLAG] || ovf_h || cap_evt;
            ctl_r[BIT_LOW_FLAG] <= ctl_wr[BIT_LOW_FLAG] || ovf_l;
        end
    end

    assign TIMER_IRQ_O = TIMER_IRQ_ENABLE_I && (ctl_r[BIT_HIGH_FLAG] ||
        (ctl_r[BIT_LOW_FLAG] && ctl_r[BIT_LOW_IRQ_EN]));

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            SFR_RDATA_O <= 8'h00;
        end
        else if (SFR_RD_I)
        begin
            case (SFR_ADDR_I)
                ADDR_CONTROL: SFR_RDATA_O <= ctl_r;
                ADDR_RELOAD_LOW: SFR_RDATA_O <= rl_l_r;
                ADDR_RELOAD_HIGH: SFR_RDATA_O <= rl_h_r;
                ADDR_COUNT_LOW: SFR_RDATA_O <= cnt_l_r;
                ADDR_COUNT_HIGH: SFR_RDATA_O <= cnt_h_r;
                default: SFR_RDATA_O <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    logic ctl_touch;
    logic cnt_touch;
    assign ctl_touch = ctl_sel && (SFR_WR_I || SFR_BIT_WR_I);
    assign cnt_touch = SFR_WR_I &&
        (SFR_ADDR_I == ADDR_COUNT_LOW || SFR_ADDR_I == ADDR_COUNT_HIGH);

    sequence s_full_wrap;
        !split && ovf_h && !cnt_touch;
    endsequence

    sequence s_flag_held;
        ctl_r[BIT_HIGH_FLAG] && !ctl_touch;
    endsequence

    chk_high_flag_set: assert property (ovf_h |=> ctl_r[BIT_HIGH_FLAG])
        else $error("high flag missed on upper wrap");
    chk_irq_high: assert property (TIMER_IRQ_ENABLE_I && ctl_r[BIT_HIGH_FLAG]
        |-> TIMER_IRQ_O)
        else $error("high flag did not raise interrupt");
    chk_no_hw_clear: assert property (s_flag_held |=> ctl_r[BIT_HIGH_FLAG])
        else $error("high flag cleared without software");
    chk_low_flag_set: assert property (ovf_l |=> ctl_r[BIT_LOW_FLAG])
        else $error("low flag missed on lower wrap");
    chk_irq_low_gate: assert property (!ctl_r[BIT_HIGH_FLAG] && !ctl_r[BIT_LOW_IRQ_EN]
        |-> !TIMER_IRQ_O)
        else $error("low flag interrupt without enable");
    chk_capture_copy: assert property (cap_evt |=>
        {rl_h_r, rl_l_r} == $past({cnt_h_r, cnt_l_r}) && ctl_r[BIT_HIGH_FLAG])
        else $error("capture did not copy counter");
    chk_reload_wrap: assert property (s_full_wrap |=>
        {cnt_h_r, cnt_l_r} == $past({rl_h_r, rl_l_r}))
        else $error("16-bit wrap did not reload");
    // a reload of 0xff onto 0xff is a legal step, so the next value is checked, not a change
    chk_split_free_low: assert property (split && !run && tick_l && !cnt_touch
        |=> cnt_l_r == ($past(cnt_l_r) == BYTE_MAX ? $past(rl_l_r) : $past(cnt_l_r) + 8'h01))
        else $error("lower byte stalled in split mode");
    chk_div_period: assert property (div_tick |-> ##(SYS_DIV) div_tick)
        else $error("system divider period wrong");
endmodule

// ---- hw/tcr_pkg.sv ----
// constants for the timer 2 control register block
package tcr_pkg;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
    // ****************************************
    // control fields and reset
    // ****************************************
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_SEL_LO = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    // ****************************************
    // selector codes and dividers
    // ****************************************
    localparam logic [1:0] SEL_DIV12_A = 2'h0;
    localparam logic [1:0] SEL_COMPARATOR = 2'h1;
    localparam logic [1:0] SEL_DIV12_B = 2'h2;
    localparam logic [1:0] SEL_LF_DIV8 = 2'h3;
    localparam int SYS_DIVIDE = 12;
    localparam int LF_DIVIDE = 8;
endpackage

// ---- hw/tcr_sync.sv ----
// three-stage synchroniser with settled level and rising-edge pulse
`timescale 1ns/1ns
module tcr_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic rise_o
);
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;

    // ****************************************
    // stages
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
        end
        else
        begin
            ff1_r <= async_i;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // level moves only once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end
        else
        begin
            if (ff2_r == ff3_r)
            begin
                level_o <= ff3_r;
            end
            rise_o <= (ff2_r == ff3_r) && ff3_r && !level_o;
        end
    end
endmodule

// ---- test/tcr_testbench.sv ----
// self-checking bench for the timer 2 control register block
`timescale 1ns/1ns
module testbench;
    import tcr_pkg::*;
    // ****************************************
    // signals, clock and reset
    // ****************************************
    localparam int SD = 4;
    localparam int LD = 2;
    typedef struct {logic [7:0] a; logic [7:0] d; logic ie; logic [7:0] q; logic irq;} tcr_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic bwr = 1'b0;
    logic [2:0] bsel = 3'h0;
    logic bval = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic usel = 1'b0;
    logic lsel = 1'b0;
    logic ie = 1'b0;
    logic cmp = 1'b0;
    logic lf = 1'b0;
    logic irq;
    logic [7:0] v;
    int fails = 0;
    int num_checks = 0;
    tcr_row_t rows [11] = '{
        '{8'hc8, 8'he3, 1'b1, 8'he3, 1'b1}, '{8'hc8, 8'h63, 1'b0, 8'h63, 1'b0},
        '{8'hc8, 8'h60, 1'b1, 8'h60, 1'b1}, '{8'hc8, 8'h20, 1'b1, 8'h20, 1'b0},
        '{8'hc8, 8'h80, 1'b1, 8'h80, 1'b1}, '{8'hca, 8'h5a, 1'b1, 8'h5a, 1'b1},
        '{8'hcb, 8'ha5, 1'b1, 8'ha5, 1'b1}, '{8'hcc, 8'h12, 1'b1, 8'h12, 1'b1},
        '{8'hcd, 8'h34, 1'b1, 8'h34, 1'b1}, '{8'hc9, 8'h77, 1'b1, 8'h00, 1'b1},
        '{8'hc8, 8'h00, 1'b1, 8'h00, 1'b0}};
    tcr_timer #(.SYS_DIV(SD), .LF_DIV(LD)) dut_u (.REF_CLK_I(clk), .RST_I(rst),
        .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_WDATA_I(wdata), .SFR_BIT_WR_I(bwr),
        .SFR_BIT_SEL_I(bsel), .SFR_BIT_VAL_I(bval), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
        .UPPER_BYTE_CLOCK_SELECT_I(usel), .LOWER_BYTE_CLOCK_SELECT_I(lsel),
        .TIMER_IRQ_ENABLE_I(ie), .COMPARATOR0_I(cmp), .LF_OSC_I(lf), .TIMER_IRQ_O(irq));
    initial
    begin
        forever #25 clk = ~clk;
    end
    // ****************************************
    // bus tasks and compares
    // ****************************************
    // all drives at the falling edge so the rising edge always sees settled inputs
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic bit_wr(input logic [7:0] a, input logic [2:0] s, input logic b);
        @(negedge clk);
        addr = a;
        bsel = s;
        bval = b;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        q = rdata;
    endtask
    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    // both sources toggle together; the selector decides which one is counted
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(negedge clk);
            cmp = 1'b1;
            lf = 1'b1;
            repeat (4) @(negedge clk);
            cmp = 1'b0;
            lf = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_reg(ADDR_CONTROL, v);
        check8("control_reset", CONTROL_RESET, v);
        check1("irq_reset", 1'b0, irq);
        $display("test reset done");
        foreach (rows[i])
        begin
            ie = rows[i].ie;
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, v);
            check8("row_read", rows[i].q, v);
            check1("row_irq", rows[i].irq, irq);
        end
        $display("test register table done");
        bit_wr(ADDR_CONTROL, 3'h5, 1'b1);
        bit_wr(ADDR_COUNT_LOW, 3'h0, 1'b1);
        rd_reg(ADDR_COUNT_LOW, v);
        check8("bit_write_ignored", 8'h12, v);
        rd_reg(ADDR_CONTROL, v);
        check8("bit_write_control", 8'h20, v);
        wr_reg(ADDR_CONTROL, 8'he3);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_reg(ADDR_CONTROL, v);
        check8("control_mid_reset", 8'h00, v);
        $display("test bit write and reset done");
        lsel = 1'b1;
        wr_reg(ADDR_RELOAD_LOW, 8'h34);
        wr_reg(ADDR_RELOAD_HIGH, 8'h12);
        wr_reg(ADDR_COUNT_LOW, 8'hfe);
        wr_reg(ADDR_COUNT_HIGH, 8'hff);
        wr_reg(ADDR_CONTROL, 8'h04);
        repeat (5) @(negedge clk);
        bit_wr(ADDR_CONTROL, 3'h2, 1'b0);
        rd_reg(ADDR_COUNT_HIGH, v);
        check8("reload_on_wrap", 8'h12, v);
        repeat (20) @(negedge clk);
        rd_reg(ADDR_CONTROL, v);
        check8("flags_after_wrap", 8'hc0, v);
        check1("wrap_irq", 1'b1, irq);
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_reg(ADDR_CONTROL, v);
        check8("flags_cleared", 8'h00, v);
        $display("test 16-bit wrap done");
        wr_reg(ADDR_RELOAD_LOW, 8'h80);
        wr_reg(ADDR_COUNT_LOW, 8'hf0);
        wr_reg(ADDR_COUNT_HIGH, 8'h50);
        wr_reg(ADDR_CONTROL, 8'h08);
        repeat (40) @(negedge clk);
        rd_reg(ADDR_COUNT_HIGH, v);
        check8("upper_gated", 8'h50, v);
        rd_reg(ADDR_COUNT_LOW, v);
        check1("lower_own_reload", 1'b1, v[7]);
        rd_reg(ADDR_CONTROL, v);
        check8("split_flags", 8'h48, v);
        check1("split_low_no_irq", 1'b0, irq);
        // upper byte on its own system clock select; twelve edges see run between the writes
        usel = 1'b1;
        wr_reg(ADDR_COUNT_HIGH, 8'h00);
        wr_reg(ADDR_CONTROL, 8'h0c);
        repeat (10) @(negedge clk);
        bit_wr(ADDR_CONTROL, 3'h2, 1'b0);
        rd_reg(ADDR_COUNT_HIGH, v);
        check8("upper_own_clock", 8'h0c, v);
        usel = 1'b0;
        wr_reg(ADDR_CONTROL, 8'h00);
        $display("test split done");
        wr_reg(ADDR_RELOAD_HIGH, 8'hee);
        wr_reg(ADDR_COUNT_LOW, 8'h00);
        wr_reg(ADDR_COUNT_HIGH, 8'h01);
        // capture kept in 16-bit mode with a fast counting clock
        wr_reg(ADDR_CONTROL, 8'h17);
        pulses(1);
        bit_wr(ADDR_CONTROL, 3'h2, 1'b0);
        rd_reg(ADDR_RELOAD_HIGH, v);
        check8("capture_copy", 8'h01, v);
        rd_reg(ADDR_CONTROL, v);
        check8("capture_flag", 8'h93, v);
        wr_reg(ADDR_CONTROL, 8'h00);
        $display("test capture done");
        lsel = 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            int e;
            e = (c == 1) ? 8 : (c == 3) ? 8 / LD : 74 / SD;
            wr_reg(ADDR_COUNT_LOW, 8'h00);
            wr_reg(ADDR_CONTROL, {6'h01, 2'(c)});
            pulses(8);
            repeat (8) @(negedge clk);
            bit_wr(ADDR_CONTROL, 3'h2, 1'b0);
            rd_reg(ADDR_COUNT_LOW, v);
            check1("alt_source_count", 1'b1, v >= 8'(e-1) && v <= 8'(e+1));
        end
        $display("test source select done");
        complete_run();
    end
    // ****************************************
    // watchdog
    // ****************************************
    // the tests take well under 2000 cycles
    initial
    begin
        #(5000 * 50);
        fails++;
        complete_run();
    end
endmodule
